// ---- include/mrs_pkg.sv ----
package mrs_pkg;

   // register addresses on the configuration port
   localparam logic [5:0]  MRS_ADDR_STRENGTH = 6'h13;
   localparam logic [5:0]  MRS_ADDR_SYNC     = 6'h14;
   localparam logic [5:0]  MRS_ADDR_TRANSMIT_CONTROL   = 6'h15;
   localparam logic [5:0]  MRS_ADDR_RXBIAS   = 6'h16;

   // values after reset
   localparam logic [7:0]  MRS_THR_RST       = 8'he0;
   localparam logic [7:0]  MRS_EST_RST       = 8'h80;
   localparam logic [15:0] MRS_SYNC_RST      = 16'ha70f;
   localparam logic [15:0] MRS_TRANSMIT_CONTROL_RST    = 16'ha0ff;
   localparam logic [15:0] MRS_RXBIAS_RST    = 16'h12e5;

   // transmit_control field positions
   localparam int MRS_TX_MIXBUF_LSB  = 14;
   localparam int MRS_TX_TURN_BIT    = 13;
   localparam int MRS_TX_VARACTOR_LSB = 11;
   localparam int MRS_TX_MIXCUR_LSB  = 9;
   localparam int MRS_TX_PACUR_LSB   = 6;
   localparam int MRS_TX_RSVD_BIT    = 5;
   localparam int MRS_TX_LEVEL_LSB   = 0;

   // receive_bias_control field positions
   localparam int MRS_RX_RSVD_LSB    = 14;
   localparam int MRS_RX_MIXBUF_LSB  = 12;
   localparam int MRS_RX_HIGH_COMP_LSB = 10;
   localparam int MRS_RX_MED_COMP_LSB  = 8;
   localparam int MRS_RX_LOW_COMP_LSB  = 6;
   localparam int MRS_RX_HIGH_CUR_LSB  = 4;
   localparam int MRS_RX_MED_CUR_LSB   = 2;
   localparam int MRS_RX_LOW_CUR_LSB   = 0;

   // strength register field positions
   localparam int MRS_THR_LSB        = 8;

   // timing
   localparam int MRS_CLK_PERIOD_NS  = 25;
   localparam int MRS_SYMBOL_NS      = 16000;
   localparam int MRS_SYMBOL_CYC     = MRS_SYMBOL_NS / MRS_CLK_PERIOD_NS;
   localparam int MRS_TURN_SHORT_US  = 128;
   localparam int MRS_TURN_LONG_US   = 192;
   localparam int MRS_TURN_SHORT_CYC = MRS_TURN_SHORT_US * 1000 / MRS_CLK_PERIOD_NS;
   localparam int MRS_TURN_LONG_CYC  = MRS_TURN_LONG_US * 1000 / MRS_CLK_PERIOD_NS;
   localparam int MRS_AVG_SYMBOLS    = 8;
   localparam int MRS_SYNC_NIBBLES   = 4;

   // clear-channel modes
   localparam logic [1:0]  MRS_CCA_LEVEL     = 2'h1;
   localparam logic [1:0]  MRS_CCA_NOPKT     = 2'h2;
   localparam logic [1:0]  MRS_CCA_BOTH      = 2'h3;

   typedef enum logic [1:0] {MRS_GAIN_HIGH, MRS_GAIN_MED, MRS_GAIN_LOW} mrs_gain_t;
   typedef enum logic {MRS_TX_IDLE, MRS_TX_WAIT} mrs_tx_state_t;

   // an all-ones sync nibble is a wildcard in receive and a zero in transmit
   function automatic logic mrs_is_wild(input logic [3:0] nib);
      return nib == 4'hf;
   endfunction

endpackage

// ---- sim/mrs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mrs_host_model
   import mrs_pkg::*;
(
   input  wire logic        core_clk_i,
   output logic [5:0]       reg_addr_o,
   output logic             reg_wr_o,
   output logic [15:0]      reg_wdata_o,
   input  wire logic [15:0] reg_rdata_i
);
   initial begin
      reg_addr_o = 6'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 16'h0000;
   end
   // reserved bits are forced here, whatever the caller passes
   task automatic write(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] v;
      v = d;
      if (a == MRS_ADDR_TRANSMIT_CONTROL) v[MRS_TX_RSVD_BIT] = 1'b1;
      if (a == MRS_ADDR_RXBIAS) v[15:14] = 2'b00;
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_wr_o <= 1'b1;
      reg_wdata_o <= v;
      @(posedge core_clk_i);
      reg_wr_o <= 1'b0;
      // released data bus must not keep the last value
      reg_wdata_o <= ~v;
   endtask
   task automatic read(input logic [5:0] a, output logic [15:0] d);
      @(posedge core_clk_i);
      reg_addr_o <= a;
      repeat (2) @(posedge core_clk_i);
      #1 d = reg_rdata_i;
   endtask
endmodule
`default_nettype wire

// ---- sim/test_mrs_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_mrs_regs
   import mrs_pkg::*;
;
   logic              clk, rst_n, rx_en, strb, rx_vld, wr, cc, vld, t_go, t_act, fs;
   logic signed [7:0] lvl;
   logic [3:0]        rx_sym, t_sym;
   logic [1:0]        gain, txmb, varac, txmc, rxmb, comp, cur;
   logic [5:0]        addr;
   logic [15:0]       wdata, rdata, d;
   logic [4:0]        pwr;
   logic [2:0]        pacur;
   logic              pkt;
   logic [1:0]        cmode;
   logic [2:0]        hyst;
   logic [3:0]        q[$];
   int                miscompares, checks_done, cycles, syncs, n;
   mrs_host_model host (.core_clk_i(clk), .reg_addr_o(addr), .reg_wr_o(wr),
      .reg_wdata_o(wdata), .reg_rdata_i(rdata));
   // short turnaround keeps the run brief
   mrs_regs #(.TURN_SHORT_CYC(20), .TURN_LONG_CYC(30)) u_mrs_regs (.core_clk_i(clk),
      .arst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .rx_enable_i(rx_en), .rx_level_i(lvl), .rx_packet_i(pkt),
      .clear_channel_mode_select_i(cmode), .clear_channel_hysteresis_i(hyst),
      .clear_channel_o(cc), .strength_estimate_valid_o(vld), .transmit_on_strobe_i(strb),
      .tx_start_o(t_go), .tx_symbol_o(t_sym), .tx_sync_active_o(t_act),
      .rx_symbol_i(rx_sym), .rx_symbol_valid_i(rx_vld), .frame_sync_o(fs),
      .agc_gain_mode_i(gain), .output_power_level_o(pwr),
      .amplifier_current_adjust_o(pacur), .transmit_mixer_buffer_bias_o(txmb),
      .transmit_mixer_varactor_o(varac), .transmit_mixer_current_o(txmc),
      .receive_mixer_buffer_bias_o(rxmb), .lna_compensation_o(comp), .lna_current_o(cur));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      host.read(a, d);
      chk("register", exp, d);
   endtask
   task automatic strobe(input int exp);
      @(posedge clk);
      strb <= 1'b1;
      @(posedge clk);
      strb <= 1'b0;
      n = 0;
      do begin @(posedge clk); #1; n++; end while (t_go !== 1'b1 && n < 100);
      chk("turnaround", 16'(exp), 16'(n));
   endtask
   task automatic rxseq(input logic [19:0] s, input int exp);
      syncs = 0;
      for (int i = 4; i >= 0; i--) begin
         @(posedge clk);
         rx_sym <= s[i*4 +: 4];
         rx_vld <= 1'b1;
         @(posedge clk);
         rx_vld <= 1'b0;
         repeat (3) @(posedge clk);
      end
      chk("frame_sync", 16'(exp), 16'(syncs));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (fs === 1'b1) syncs++;
      // whole run needs about 13k cycles
      if (cycles == 40000) begin
         miscompares++;
         finish_test();
      end
   end
   initial begin
      {rst_n, rx_en, strb, rx_vld, rx_sym, gain} = '0;
      lvl = 8'sh00;
      pkt = 1'b0;
      cmode = 2'h1;
      hyst = 3'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(MRS_ADDR_STRENGTH, 16'he080);
      rd(MRS_ADDR_SYNC, 16'ha70f);
      rd(MRS_ADDR_TRANSMIT_CONTROL, 16'ha0ff);
      rd(MRS_ADDR_RXBIAS, 16'h12e5);
      chk("fields", 16'hfb90, {pwr, pacur, txmb, rxmb, varac, txmc});
      for (int g = 0; g < 4; g++) begin
         @(posedge clk);
         gain <= 2'(g);
         @(posedge clk);
         #1 chk("lna", {12'h000, comp, cur}, {12'h000, g == 0 ? 4'h2 : g == 1 ? 4'h9 : 4'hd});
      end
      rd(6'h20, 16'h0000);
      host.write(MRS_ADDR_STRENGTH, 16'h1234);
      rd(MRS_ADDR_STRENGTH, 16'h1280);
      host.write(MRS_ADDR_STRENGTH, 16'he000);
      host.write(MRS_ADDR_RXBIAS, 16'hffff);
      rd(MRS_ADDR_RXBIAS, 16'h3fff);
      $display("test registers done");
      host.write(MRS_ADDR_SYNC, 16'h1f23);
      host.write(MRS_ADDR_TRANSMIT_CONTROL, 16'h0000);
      rd(MRS_ADDR_TRANSMIT_CONTROL, 16'h0020);
      strobe(20);
      n = 0;
      // first active cycle still shows the old symbol
      while (n < 4000 && !(q.size() > 0 && t_act !== 1'b1)) begin
         @(posedge clk);
         #1 n = (t_act === 1'b1) ? n + 1 : n;
         if (n > 1 && t_act === 1'b1 && (q.size() == 0 || t_sym !== q[$])) q.push_back(t_sym);
      end
      chk("tx_symbols", {q.size() == 4 ? 16'h0 : 16'hffff}, 16'h0000);
      for (int i = 0; i < q.size() && i < 4; i++)
         chk("tx_symbol", {12'h000, 4'(16'h1023 >> (4 * i))}, {12'h000, q[i]});
      host.write(MRS_ADDR_TRANSMIT_CONTROL, 16'ha0ff);
      strobe(30);
      $display("test transmit done");
      host.write(MRS_ADDR_SYNC, 16'ha70f);
      rxseq(20'h0507a, 0);
      rxseq(20'h0007b, 0);
      rxseq(20'h9007a, 1);
      $display("test receive done");
      @(posedge clk);
      lvl <= -8'sd50;
      rx_en <= 1'b1;
      n = 0;
      while (vld !== 1'b1 && n < 6000) begin @(posedge clk); #1 n++; end
      chk("valid_delay", 16'(n >= 7 * 640 && n <= 8 * 640 + 5), 16'h0001);
      rd(MRS_ADDR_STRENGTH, 16'he0ce);
      chk("clear_channel", {15'h0, cc}, 16'h0001);
      lvl <= -8'sd10;
      repeat (8 * 640 + 8) @(posedge clk);
      rd(MRS_ADDR_STRENGTH, 16'he0f6);
      chk("clear_channel", {15'h0, cc}, 16'h0000);
      rx_en <= 1'b0;
      rd(MRS_ADDR_STRENGTH, 16'he080);
      chk("valid", {15'h0, vld}, 16'h0000);
      @(posedge clk);
      cmode <= 2'h2;
      repeat (2) @(posedge clk);
      #1 chk("clear_channel", 16'h0001, {15'h0, cc});
      @(posedge clk);
      pkt <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("clear_channel", 16'h0000, {15'h0, cc});
      $display("test strength done");
      finish_test();
   end
endmodule
`default_nettype wire

// ---- src/mrs_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module mrs_regs
   import mrs_pkg::*;
#(
   parameter int TURN_SHORT_CYC = MRS_TURN_SHORT_CYC,
   parameter int TURN_LONG_CYC  = MRS_TURN_LONG_CYC
)(
   input  wire logic              core_clk_i,
   input  wire logic              arst_n_i,
   input  wire logic [5:0]        reg_addr_i,
   input  wire logic              reg_wr_i,
   input  wire logic [15:0]       reg_wdata_i,
   output logic [15:0]            reg_rdata_o,
   input  wire logic              rx_enable_i,
   input  wire logic signed [7:0] rx_level_i,
   input  wire logic              rx_packet_i,
   input  wire logic [1:0]        clear_channel_mode_select_i,
   input  wire logic [2:0]        clear_channel_hysteresis_i,
   output logic                   clear_channel_o,
   output logic                   strength_estimate_valid_o,
   input  wire logic              transmit_on_strobe_i,
   output logic                   tx_start_o,
   output logic [3:0]             tx_symbol_o,
   output logic                   tx_sync_active_o,
   input  wire logic [3:0]        rx_symbol_i,
   input  wire logic              rx_symbol_valid_i,
   output logic                   frame_sync_o,
   input  wire logic [1:0]        agc_gain_mode_i,
   output logic [4:0]             output_power_level_o,
   output logic [2:0]             amplifier_current_adjust_o,
   output logic [1:0]             transmit_mixer_buffer_bias_o,
   output logic [1:0]             transmit_mixer_varactor_o,
   output logic [1:0]             transmit_mixer_current_o,
   output logic [1:0]             receive_mixer_buffer_bias_o,
   output logic [1:0]             lna_compensation_o,
   output logic [1:0]             lna_current_o
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0]          clear_channel_threshold;
   logic [15:0]         frame_sync_pattern;
   logic [15:0]         transmit_control;
   logic [15:0]         receive_bias_control;
   logic signed [7:0]   strength_estimate;
   logic [9:0]          sym_cnt;
   logic                sym_tick;
   mrs_tx_state_t       tx_state;
   logic [12:0]         turn_cnt;
   logic [12:0]         turn_target;
   logic signed [9:0]   low_mark;
   logic                below_low;
   logic                below_thr;
   logic [15:0]         next_rdata;

   ////////////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clear_channel_threshold <= MRS_THR_RST;
      end else if (reg_wr_i && reg_addr_i == MRS_ADDR_STRENGTH) begin
         // low byte is the estimate, so only the high byte lands
         clear_channel_threshold <= reg_wdata_i[MRS_THR_LSB +: 8];
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         frame_sync_pattern <= MRS_SYNC_RST;
      end else if (reg_wr_i && reg_addr_i == MRS_ADDR_SYNC) begin
         frame_sync_pattern <= reg_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         transmit_control <= MRS_TRANSMIT_CONTROL_RST;
      end else if (reg_wr_i && reg_addr_i == MRS_ADDR_TRANSMIT_CONTROL) begin
         transmit_control <= reg_wdata_i;
         // bit 5 holds one whatever the host sends
         transmit_control[MRS_TX_RSVD_BIT] <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         receive_bias_control <= MRS_RXBIAS_RST;
      end else if (reg_wr_i && reg_addr_i == MRS_ADDR_RXBIAS) begin
         receive_bias_control <= reg_wdata_i;
         receive_bias_control[MRS_RX_RSVD_LSB +: 2] <= 2'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register reads, one cycle after the address; unmapped reads zero
   always_comb begin
      unique case (reg_addr_i)
         MRS_ADDR_STRENGTH: next_rdata = {clear_channel_threshold, strength_estimate};
         MRS_ADDR_SYNC:     next_rdata = frame_sync_pattern;
         MRS_ADDR_TRANSMIT_CONTROL:   next_rdata = transmit_control;
         MRS_ADDR_RXBIAS:   next_rdata = receive_bias_control;
         default:           next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_o <= '0;
      end else begin
         reg_rdata_o <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // symbol timebase, free running
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sym_cnt <= '0;
      end else begin
         sym_cnt <= (sym_cnt == 10'(MRS_SYMBOL_CYC - 1)) ? 10'h000 : sym_cnt + 10'h001;
      end
   end
   assign sym_tick = sym_cnt == 10'(MRS_SYMBOL_CYC - 1);

   mrs_strength_avg u_avg (
      .core_clk_i  (core_clk_i),
      .arst_n_i    (arst_n_i),
      .rx_enable_i (rx_enable_i),
      .sym_tick_i  (sym_tick),
      .sample_i    (rx_level_i),
      .estimate_o  (strength_estimate),
      .valid_o     (strength_estimate_valid_o)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // clear channel; widened so threshold minus hysteresis cannot wrap
   assign low_mark  = 10'(signed'(clear_channel_threshold))
                      - 10'(signed'({1'b0, clear_channel_hysteresis_i}));
   assign below_low = 10'(strength_estimate) < low_mark;
   assign below_thr = strength_estimate < signed'(clear_channel_threshold);

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clear_channel_o <= 1'b0;
      end else begin
         unique case (clear_channel_mode_select_i)
            MRS_CCA_NOPKT: clear_channel_o <= !rx_packet_i;
            MRS_CCA_BOTH: begin
               if (!below_thr || rx_packet_i) clear_channel_o <= 1'b0;
               else if (below_low) clear_channel_o <= 1'b1;
            end
            // reserved mode 0 behaves as mode 1
            default: begin
               if (!below_thr) clear_channel_o <= 1'b0;
               else if (below_low) clear_channel_o <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // transmit turnaround
   assign turn_target = transmit_control[MRS_TX_TURN_BIT] ? 13'(TURN_LONG_CYC - 1)
                                                          : 13'(TURN_SHORT_CYC - 1);

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_state   <= MRS_TX_IDLE;
         turn_cnt   <= '0;
         tx_start_o <= 1'b0;
      end else begin
         tx_start_o <= 1'b0;
         unique case (tx_state)
            MRS_TX_IDLE: begin
               if (transmit_on_strobe_i) begin
                  tx_state <= MRS_TX_WAIT;
                  turn_cnt <= '0;
               end
            end
            MRS_TX_WAIT: begin
               // a repeated strobe during the wait is ignored
               if (turn_cnt >= turn_target) begin
                  tx_state   <= MRS_TX_IDLE;
                  tx_start_o <= 1'b1;
               end else begin
                  turn_cnt <= turn_cnt + 13'h0001;
               end
            end
         endcase
      end
   end

   mrs_sync_unit u_sync (
      .core_clk_i        (core_clk_i),
      .arst_n_i          (arst_n_i),
      .pattern_i         (frame_sync_pattern),
      .sym_tick_i        (sym_tick),
      .tx_start_i        (tx_start_o),
      .tx_symbol_o       (tx_symbol_o),
      .tx_active_o       (tx_sync_active_o),
      .rx_symbol_i       (rx_symbol_i),
      .rx_symbol_valid_i (rx_symbol_valid_i),
      .frame_sync_o      (frame_sync_o)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // analog settings
   assign output_power_level_o         = transmit_control[MRS_TX_LEVEL_LSB +: 5];
   assign amplifier_current_adjust_o   = transmit_control[MRS_TX_PACUR_LSB +: 3];
   assign transmit_mixer_buffer_bias_o = transmit_control[MRS_TX_MIXBUF_LSB +: 2];
   assign transmit_mixer_varactor_o    = transmit_control[MRS_TX_VARACTOR_LSB +: 2];
   assign transmit_mixer_current_o     = transmit_control[MRS_TX_MIXCUR_LSB +: 2];
   assign receive_mixer_buffer_bias_o  = receive_bias_control[MRS_RX_MIXBUF_LSB +: 2];

   always_comb begin
      unique case (agc_gain_mode_i)
         MRS_GAIN_HIGH: begin
            lna_compensation_o = receive_bias_control[MRS_RX_HIGH_COMP_LSB +: 2];
            lna_current_o      = receive_bias_control[MRS_RX_HIGH_CUR_LSB +: 2];
         end
         MRS_GAIN_MED: begin
            lna_compensation_o = receive_bias_control[MRS_RX_MED_COMP_LSB +: 2];
            lna_current_o      = receive_bias_control[MRS_RX_MED_CUR_LSB +: 2];
         end
         // the unused code falls back to low gain settings
         default: begin
            lna_compensation_o = receive_bias_control[MRS_RX_LOW_COMP_LSB +: 2];
            lna_current_o      = receive_bias_control[MRS_RX_LOW_CUR_LSB +: 2];
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_strobe_idle;
      transmit_on_strobe_i && tx_state == MRS_TX_IDLE;
   endsequence

   property p_turn_short;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      s_strobe_idle ##0 !transmit_control[MRS_TX_TURN_BIT] |->
      !tx_start_o [*8] ##1 !tx_start_o;
   endproperty
   a_turn_short: assert property (p_turn_short) else $error("turnaround start too early");

   property p_turn_bounded;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      tx_state == MRS_TX_WAIT && turn_cnt >= turn_target |=> tx_start_o;
   endproperty
   a_turn_bounded: assert property (p_turn_bounded) else $error("turnaround end missed");

   property p_est_ro;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      reg_wr_i && reg_addr_i == MRS_ADDR_STRENGTH |=>
      clear_channel_threshold == $past(reg_wdata_i[15:8]);
   endproperty
   a_est_ro: assert property (p_est_ro) else $error("threshold write lost");

   property p_cca_set;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      clear_channel_mode_select_i == MRS_CCA_LEVEL && below_low |=> clear_channel_o;
   endproperty
   a_cca_set: assert property (p_cca_set) else $error("clear channel not raised");

   property p_cca_clr;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      clear_channel_mode_select_i == MRS_CCA_LEVEL && !below_thr |=> !clear_channel_o;
   endproperty
   a_cca_clr: assert property (p_cca_clr) else $error("clear channel not dropped");

   property p_invalid_est;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      !strength_estimate_valid_o |-> strength_estimate == signed'(MRS_EST_RST);
   endproperty
   a_invalid_est: assert property (p_invalid_est) else $error("estimate not -128");

   property p_valid_off;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      !rx_enable_i ##1 !rx_enable_i |=> !strength_estimate_valid_o;
   endproperty
   a_valid_off: assert property (p_valid_off) else $error("valid without receiver");

   property p_tx_rsvd;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      transmit_control[MRS_TX_RSVD_BIT] && receive_bias_control[15:14] == 2'h0;
   endproperty
   a_tx_rsvd: assert property (p_tx_rsvd) else $error("reserved bits stored");

   property p_wild_tx;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      tx_sync_active_o |-> tx_symbol_o != 4'hf;
   endproperty
   a_wild_tx: assert property (p_wild_tx) else $error("all-ones symbol sent");

endmodule
`default_nettype wire

// ---- src/mrs_strength_avg.sv ----
`timescale 1ns/1ps
`default_nettype none
module mrs_strength_avg
   import mrs_pkg::*;
(
   input  wire logic              core_clk_i,
   input  wire logic              arst_n_i,
   input  wire logic              rx_enable_i,
   input  wire logic              sym_tick_i,
   input  wire logic signed [7:0] sample_i,
   output logic signed [7:0]      estimate_o,
   output logic                   valid_o
);
   logic signed [7:0] hist [MRS_AVG_SYMBOLS];
   logic [3:0]        fill;
   logic signed [10:0] sum;

   always_comb begin
      sum = '0;
      for (int i = 0; i < MRS_AVG_SYMBOLS; i++) begin
         sum = sum + 11'(hist[i]);
      end
   end

   // window of the last eight symbol samples
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < MRS_AVG_SYMBOLS; i++) hist[i] <= '0;
      end else if (rx_enable_i && sym_tick_i) begin
         hist[0] <= sample_i;
         for (int i = 1; i < MRS_AVG_SYMBOLS; i++) hist[i] <= hist[i-1];
      end
   end

   // valid only after eight symbol ticks with the receiver on, the first symbol possibly partial
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fill <= '0;
      end else if (!rx_enable_i) begin
         fill <= '0;
      end else if (sym_tick_i && fill != 4'(MRS_AVG_SYMBOLS)) begin
         fill <= fill + 4'h1;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         estimate_o <= MRS_EST_RST;
         valid_o    <= 1'b0;
      end else begin
         valid_o    <= fill == 4'(MRS_AVG_SYMBOLS);
         estimate_o <= (fill == 4'(MRS_AVG_SYMBOLS)) ? 8'(sum >>> 3) : MRS_EST_RST;
      end
   end
endmodule
`default_nettype wire

// ---- src/mrs_sync_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module mrs_sync_unit
   import mrs_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic [15:0] pattern_i,
   input  wire logic        sym_tick_i,
   input  wire logic        tx_start_i,
   output logic [3:0]       tx_symbol_o,
   output logic             tx_active_o,
   input  wire logic [3:0]  rx_symbol_i,
   input  wire logic        rx_symbol_valid_i,
   output logic             frame_sync_o
);
   logic [1:0]  tx_idx;
   logic [19:0] rx_hist;
   logic [2:0]  rx_count;
   logic [4:0]  slot_ok;
   logic [2:0]  first_req;
   logic        match;
   logic        match_d;

   // transmit: least significant nibble first, wildcards sent as zero
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_idx      <= '0;
         tx_active_o <= 1'b0;
      end else if (tx_start_i) begin
         tx_idx      <= '0;
         tx_active_o <= 1'b1;
      end else if (tx_active_o && sym_tick_i) begin
         tx_idx      <= tx_idx + 2'h1;
         tx_active_o <= tx_idx != 2'(MRS_SYNC_NIBBLES - 1);
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_symbol_o <= '0;
      end else begin
         tx_symbol_o <= mrs_is_wild(pattern_i[tx_idx*4 +: 4]) ? 4'h0
                        : pattern_i[tx_idx*4 +: 4];
      end
   end

   // receive: slot k+1 of the history holds nibble k, slot 0 the oldest
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_hist  <= '0;
         rx_count <= '0;
      end else if (rx_symbol_valid_i) begin
         rx_hist  <= {rx_symbol_i, rx_hist[19:4]};
         rx_count <= (rx_count == 3'h5) ? rx_count : rx_count + 3'h1;
      end
   end

   always_comb begin
      first_req = 3'(MRS_SYNC_NIBBLES);
      for (int k = MRS_SYNC_NIBBLES - 1; k >= 0; k--) begin
         if (!mrs_is_wild(pattern_i[k*4 +: 4])) first_req = 3'(k);
      end
   end

   for (genvar k = 0; k < MRS_SYNC_NIBBLES; k++) begin : g_slot
      assign slot_ok[k+1] = mrs_is_wild(pattern_i[k*4 +: 4])
                            || rx_hist[(k+1)*4 +: 4] == pattern_i[k*4 +: 4];
   end
   // implicit zero just ahead of the first nibble that must match
   assign slot_ok[0] = rx_hist[first_req*4 +: 4] == 4'h0;
   assign match = &slot_ok[4:1] && slot_ok[0] && rx_count == 3'h5;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         frame_sync_o <= 1'b0;
         match_d      <= 1'b0;
      end else begin
         // one pulse per match, however long the history keeps matching
         match_d      <= match;
         frame_sync_o <= match && !match_d;
      end
   end
endmodule
`default_nettype wire
